/* File: ssdc_device.sv */
// synthesizer end: serial shift register, four latches and divider logic
// assumes link pins, reference and feedback inputs synchronous to clk
//
// What this block does
// [RULE1] sample data on each serial clock rise
// [RULE2] msb first; last two bits pick latch
// [RULE3] load strobe rise copies word to latch
// [RULE4] observe pin shows lock, feedback or reference
// [RULE5] integer divide is 9 bits, 31..511
// [RULE6] host keeps numerator below the modulus
// [RULE7] host keeps modulus within 2..4095
// [RULE8] 4-bit reference divider, ratios 1..15
// [RULE9] compare rate is ref times (1+D) over R
// [RULE10] feedback divides by int plus frac/mod
// [RULE11] 24-bit shift register, one bit per rising edge
// [RULE12] codes 0..3 pick N, R, control, noise
// [RULE13] new modulus applies after next N write
// [RULE14] latches hold until addressed by a load
// [RULE15] host shifts one whole word per load
`timescale 1ns/1ps
`default_nettype none
module ssdc_device (
   input wire logic clk,
   input wire logic rst,
   ssdc_if.deviceEnd link,
   input wire logic referenceInput,
   input wire logic feedbackRfInput,
   output logic [ssdc_pkg::INT_W-1:0] intValue,
   output logic [ssdc_pkg::FRAC_W-1:0] fracValue,
   output logic [ssdc_pkg::MOD_W-1:0] stepDenominator,
   output logic [ssdc_pkg::RDIV_W-1:0] refDivRatio,
   output logic doublerOn,
   output logic [ssdc_pkg::WORD_W-1:0] controlWord,
   output logic [ssdc_pkg::WORD_W-1:0] noiseWord,
   output logic compareTick,
   output logic feedbackTick,
   output logic lockDetect
);
   typedef struct packed {
      logic [ssdc_pkg::WORD_W-1:0] shift;
      logic [ssdc_pkg::WORD_W-1:0] latchN;
      logic [ssdc_pkg::WORD_W-1:0] latchR;
      logic [ssdc_pkg::WORD_W-1:0] latchCtrl;
      logic [ssdc_pkg::WORD_W-1:0] latchNoise;
      logic [ssdc_pkg::MOD_W-1:0] modActive;
      logic sclkPrev;
      logic lePrev;
      logic refPrev;
      logic fbPrev;
      logic [ssdc_pkg::RDIV_W-1:0] refCnt;
      logic [ssdc_pkg::INT_W:0] fbCnt;
      logic [ssdc_pkg::MOD_W-1:0] acc;
      logic carry;
      logic [1:0] fbPerRef;
      logic lock;
      logic cmpTick;
      logic fbTick;
      logic obs;
   } ssdc_dev_state_t;

   ssdc_dev_state_t st_q;
   ssdc_dev_state_t st_d;

   logic [ssdc_pkg::INT_W-1:0] intNow;
   logic [ssdc_pkg::FRAC_W-1:0] fracNow;
   logic [ssdc_pkg::RDIV_W-1:0] rNow;
   logic [ssdc_pkg::OBS_W-1:0] obsSel;
   logic dblNow;

   assign intNow = st_q.latchN[ssdc_pkg::INT_LSB +: ssdc_pkg::INT_W];
   assign fracNow = st_q.latchN[ssdc_pkg::FRAC_LSB +: ssdc_pkg::FRAC_W];
   assign rNow = st_q.latchR[ssdc_pkg::RDIV_LSB +: ssdc_pkg::RDIV_W];
   assign obsSel = st_q.latchR[ssdc_pkg::OBS_LSB +: ssdc_pkg::OBS_W];
   assign dblNow = st_q.latchCtrl[ssdc_pkg::DBL_BIT];

   always_comb begin
      logic sclkRise;
      logic leRise;
      logic refEdge;
      logic fbRise;
      logic [ssdc_pkg::RDIV_W:0] refNext;
      logic [ssdc_pkg::INT_W:0] fbNext;
      logic [ssdc_pkg::INT_W:0] nNow;
      logic [ssdc_pkg::MOD_W:0] sum;
      sclkRise = 1'b0;
      leRise = 1'b0;
      refEdge = 1'b0;
      fbRise = 1'b0;
      refNext = '0;
      fbNext = '0;
      nNow = '0;
      sum = '0;
      st_d = st_q;
      st_d.sclkPrev = link.sclk;
      st_d.lePrev = link.loadStrobe;
      st_d.refPrev = referenceInput;
      st_d.fbPrev = feedbackRfInput;
      sclkRise = link.sclk & ~st_q.sclkPrev;
      leRise = link.loadStrobe & ~st_q.lePrev;

      if (sclkRise) begin
         st_d.shift = {st_q.shift[ssdc_pkg::WORD_W-2:0], link.sdata}; // [RULE1] [RULE11] [RULE2]
      end
      // the word loaded is the one present before this cycle's shift
      if (leRise) begin // [RULE3] [RULE14] [RULE15]
         case (st_q.shift[ssdc_pkg::SEL_LSB +: ssdc_pkg::SEL_W]) // [RULE2]
            ssdc_pkg::SEL_NDIV: begin // [RULE12]
               st_d.latchN = st_q.shift;
               st_d.modActive = st_q.latchR[ssdc_pkg::MOD_LSB +:
                                            ssdc_pkg::MOD_W]; // [RULE13]
            end
            ssdc_pkg::SEL_RDIV: begin
               st_d.latchR = st_q.shift; // [RULE13]
            end
            ssdc_pkg::SEL_CTRL: begin
               st_d.latchCtrl = st_q.shift;
            end
            default: begin
               st_d.latchNoise = st_q.shift;
            end
         endcase
      end

      // reference counter counts both edges when doubled
      refEdge = (referenceInput & ~st_q.refPrev)
              | (dblNow & ~referenceInput & st_q.refPrev); // [RULE9]
      st_d.cmpTick = 1'b0;
      if (refEdge) begin
         refNext = {1'b0, st_q.refCnt} + 5'h01;
         if (refNext >= {1'b0, rNow}) begin // [RULE8] [RULE9]
            st_d.refCnt = '0;
            st_d.cmpTick = 1'b1;
         end else begin
            st_d.refCnt = refNext[ssdc_pkg::RDIV_W-1:0];
         end
      end

      // feedback divides by int, or int+1 when the accumulator carried
      fbRise = feedbackRfInput & ~st_q.fbPrev;
      nNow = {1'b0, intNow} + {{ssdc_pkg::INT_W{1'b0}}, st_q.carry}; // [RULE5]
      st_d.fbTick = 1'b0;
      if (fbRise) begin
         fbNext = st_q.fbCnt + 10'h001;
         if (fbNext >= nNow) begin // [RULE10]
            st_d.fbCnt = '0;
            st_d.fbTick = 1'b1;
            sum = {1'b0, st_q.acc} + {1'b0, fracNow};
            if (sum >= {1'b0, st_q.modActive}) begin // [RULE10]
               sum = sum - {1'b0, st_q.modActive};
               st_d.carry = 1'b1;
            end else begin
               st_d.carry = 1'b0;
            end
            st_d.acc = sum[ssdc_pkg::MOD_W-1:0];
         end else begin
            st_d.fbCnt = fbNext;
         end
      end

      // lock means exactly one feedback tick per compare period
      if (st_q.cmpTick) begin
         st_d.lock = (st_q.fbPerRef == 2'h1);
         st_d.fbPerRef = {1'b0, st_q.fbTick};
      end else if (st_q.fbTick && st_q.fbPerRef != 2'h3) begin
         st_d.fbPerRef = st_q.fbPerRef + 2'h1;
      end

      case (obsSel) // [RULE4]
         ssdc_pkg::OBS_LOCK: st_d.obs = st_q.lock;
         ssdc_pkg::OBS_FB: st_d.obs = st_q.fbTick;
         ssdc_pkg::OBS_REF: st_d.obs = st_q.cmpTick;
         default: st_d.obs = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.modActive <= ssdc_pkg::MOD_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign link.observeOut = st_q.obs;
   assign intValue = intNow;
   assign fracValue = fracNow;
   assign stepDenominator = st_q.modActive;
   assign refDivRatio = rNow;
   assign doublerOn = dblNow;
   assign controlWord = st_q.latchCtrl;
   assign noiseWord = st_q.latchNoise;
   assign compareTick = st_q.cmpTick;
   assign feedbackTick = st_q.fbTick;
   assign lockDetect = st_q.lock;
endmodule
`default_nettype wire

/* File: ssdc_pkg.sv */
// constants shared by both ends of the synthesizer serial programming link
// assumes a single 100 MHz system clock on both ends
package ssdc_pkg;
   localparam int WORD_W = 24;
   localparam int SEL_W = 2;
   localparam int INT_W = 9;
   localparam int FRAC_W = 12;
   localparam int MOD_W = 12;
   localparam int RDIV_W = 4;
   localparam int OBS_W = 3;
   // field positions inside the 24-bit word
   localparam int SEL_LSB = 0;
   localparam int FRAC_LSB = 2;
   localparam int INT_LSB = 14;
   localparam int MOD_LSB = 2;
   localparam int RDIV_LSB = 14;
   localparam int OBS_LSB = 20;
   localparam int DBL_BIT = 11;
   // latch selection codes in the two lowest bits
   localparam logic [1:0] SEL_NDIV = 2'h0;
   localparam logic [1:0] SEL_RDIV = 2'h1;
   localparam logic [1:0] SEL_CTRL = 2'h2;
   localparam logic [1:0] SEL_NOISE = 2'h3;
   // observation output selections, anything else drives low
   localparam logic [2:0] OBS_LOCK = 3'h1;
   localparam logic [2:0] OBS_FB = 3'h2;
   localparam logic [2:0] OBS_REF = 3'h3;
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
   localparam logic [MOD_W-1:0] MOD_RESET = 12'h002;
   // serial timing, least times in ns, rounded up to clock cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_CLK_HIGH_NS = 25;
   localparam int T_CLK_LOW_NS = 25;
   localparam int T_LE_SETUP_NS = 20;
   localparam int T_LE_WIDTH_NS = 20;
   localparam int CLK_HIGH_CYC = (T_CLK_HIGH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int CLK_LOW_CYC = (T_CLK_LOW_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int LE_SETUP_CYC = (T_LE_SETUP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int LE_WIDTH_CYC = (T_LE_WIDTH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int WAIT_W = 4;
   localparam int BIT_W = 5;
endpackage

/* File: ssdc_if.sv */
// three-wire programming link plus the observation pin
// assumes both ends run from the same clk; no clock travels in here
`timescale 1ns/1ps
`default_nettype none
interface ssdc_if;
   logic sclk;
   logic sdata;
   logic loadStrobe;
   logic observeOut;
   modport hostEnd(output sclk, output sdata, output loadStrobe,
                   input observeOut);
   modport deviceEnd(input sclk, input sdata, input loadStrobe,
                     output observeOut);
endinterface
`default_nettype wire

/* File: ssdc_host.sv */
// host end: shifts one 24-bit word msb first, then pulses the load strobe
// assumes the same clk as the device; serial clock is divided from clk
`timescale 1ns/1ps
`default_nettype none
module ssdc_host (
   input wire logic clk,
   input wire logic rst,
   ssdc_if.hostEnd link,
   input wire logic start,
   input wire logic [ssdc_pkg::WORD_W-1:0] word,
   output logic busy,
   output logic done,
   output logic observeSeen
);
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0,
      HS_LOW = 3'h1,
      HS_HIGH = 3'h3,
      HS_GAP = 3'h2,
      HS_LOAD = 3'h6
   } ssdc_host_state_t;

   typedef struct packed {
      ssdc_host_state_t state;
      logic [ssdc_pkg::WORD_W-1:0] shift;
      logic [ssdc_pkg::BIT_W-1:0] bitCnt;
      logic [ssdc_pkg::WAIT_W-1:0] waitCnt;
      logic sclk;
      logic sdata;
      logic le;
      logic busy;
      logic done;
      logic obs;
   } ssdc_host_regs_t;

   localparam logic [ssdc_pkg::WAIT_W-1:0] LOW_W =
      ssdc_pkg::WAIT_W'(ssdc_pkg::CLK_LOW_CYC - 1);
   localparam logic [ssdc_pkg::WAIT_W-1:0] HIGH_W =
      ssdc_pkg::WAIT_W'(ssdc_pkg::CLK_HIGH_CYC - 1);
   localparam logic [ssdc_pkg::WAIT_W-1:0] SETUP_W =
      ssdc_pkg::WAIT_W'(ssdc_pkg::LE_SETUP_CYC - 1);
   localparam logic [ssdc_pkg::WAIT_W-1:0] WIDTH_W =
      ssdc_pkg::WAIT_W'(ssdc_pkg::LE_WIDTH_CYC - 1);
   localparam logic [ssdc_pkg::BIT_W-1:0] LAST_BIT =
      ssdc_pkg::BIT_W'(ssdc_pkg::WORD_W - 1);

   ssdc_host_regs_t r_q;
   ssdc_host_regs_t r_d;

   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.obs = link.observeOut;
      if (r_q.waitCnt != '0) begin
         r_d.waitCnt = r_q.waitCnt - 4'h1;
      end
      case (r_q.state)
         HS_IDLE: begin
            if (start) begin
               // whole word, msb out first [RULE2] [RULE15]
               r_d.shift = word;
               r_d.sdata = word[ssdc_pkg::WORD_W-1];
               r_d.bitCnt = LAST_BIT;
               r_d.waitCnt = LOW_W;
               r_d.busy = 1'b1;
               r_d.state = HS_LOW;
            end
         end
         HS_LOW: begin
            if (r_q.waitCnt == '0) begin
               r_d.sclk = 1'b1;
               r_d.waitCnt = HIGH_W;
               r_d.state = HS_HIGH;
            end
         end
         HS_HIGH: begin
            // data changes with the falling edge, giving hold and setup
            if (r_q.waitCnt == '0) begin
               r_d.sclk = 1'b0;
               if (r_q.bitCnt == '0) begin
                  r_d.waitCnt = SETUP_W;
                  r_d.state = HS_GAP;
               end else begin
                  r_d.shift = {r_q.shift[ssdc_pkg::WORD_W-2:0], 1'b0};
                  r_d.sdata = r_q.shift[ssdc_pkg::WORD_W-2];
                  r_d.bitCnt = r_q.bitCnt - 5'h01;
                  r_d.waitCnt = LOW_W;
                  r_d.state = HS_LOW;
               end
            end
         end
         HS_GAP: begin
            if (r_q.waitCnt == '0) begin
               r_d.le = 1'b1; // [RULE3]
               r_d.waitCnt = WIDTH_W;
               r_d.state = HS_LOAD;
            end
         end
         HS_LOAD: begin
            if (r_q.waitCnt == '0) begin
               r_d.le = 1'b0;
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
               r_d.state = HS_IDLE;
            end
         end
         default: begin
            r_d.state = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
         r_q.state <= HS_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign link.sclk = r_q.sclk;
   assign link.sdata = r_q.sdata;
   assign link.loadStrobe = r_q.le;
   assign busy = r_q.busy;
   assign done = r_q.done;
   assign observeSeen = r_q.obs;
endmodule
`default_nettype wire

/* File: ssdc_props.sv */
// checker for the programming link wires between host and device ends
// assumes link signals are registered on clk of both ends
`timescale 1ns/1ps
`default_nettype none
module ssdc_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic loadStrobe,
   input wire logic observeOut
);
   logic [5:0] riseCnt_q;
   logic loaded_q;
   // counts serial clock rises since the last load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         riseCnt_q <= 6'h00;
         loaded_q <= 1'b0;
      end else if (loadStrobe) begin
         riseCnt_q <= 6'h00;
         loaded_q <= 1'b1;
      end else if ($rose(sclk)) begin
         riseCnt_q <= riseCnt_q + 6'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   word_count_a: assert property (
      $rose(loadStrobe) |-> riseCnt_q == 6'h18)
      else $error("load without exactly one word");
   data_hold_a: assert property (
      $rose(sclk) |-> ##1 $stable(sdata) ##1 $stable(sdata))
      else $error("data moved while serial clock high");
   high_phase_a: assert property (
      $rose(sclk) |-> sclk[*3] ##1 !sclk)
      else $error("serial clock high phase length");
   low_phase_a: assert property (
      $fell(sclk) |-> !sclk[*3])
      else $error("serial clock low phase too short");
   strobe_width_a: assert property (
      $rose(loadStrobe) |-> loadStrobe[*2] ##1 !loadStrobe)
      else $error("load strobe width");
   quiet_shift_a: assert property (
      loadStrobe |-> !sclk)
      else $error("serial clock during load");
   strobe_setup_a: assert property (
      $rose(loadStrobe) |-> !$past(sclk) && !$past(sclk, 2))
      else $error("load too soon after last bit");
   observe_idle_a: assert property (
      !loaded_q |-> !observeOut)
      else $error("observe pin active before any load");
endmodule
`default_nettype wire

/* File: synth_serial_divider_config_tb.sv */
// bench: host end programs the device end over the link interface
// assumes 100 MHz clk; reference and feedback inputs toggle each cycle
`timescale 1ns/1ps
`default_nettype none
module synth_serial_divider_config_tb;
   typedef struct packed {
      logic [ssdc_pkg::INT_W-1:0] n;
      logic [ssdc_pkg::FRAC_W-1:0] f;
      logic [ssdc_pkg::MOD_W-1:0] m;
      logic [ssdc_pkg::RDIV_W-1:0] r;
      logic d;
      logic [ssdc_pkg::WORD_W-1:0] c;
      logic [ssdc_pkg::WORD_W-1:0] s;
   } ssdc_snap_t;
   logic clk, rst, start, busy, done, obsSeen, cTick, fTick, lock, dly;
   logic reference_input = 1'b0;
   logic fbIn = 1'b0;
   logic [23:0] word;
   logic [31:0] lfsr = 32'h4F1B88E8;
   ssdc_snap_t e, act, q[$];
   logic [11:0] pendMod;
   int errors = 0;
   int cmp_count = 0;
   int obsSel = 0;
   ssdc_if link();
   ssdc_host i_ssdc_host (.clk(clk), .rst(rst), .link(link),
      .start(start), .word(word), .busy(busy), .done(done),
      .observeSeen(obsSeen));
   ssdc_device i_ssdc_device (.clk(clk), .rst(rst), .link(link),
      .referenceInput(reference_input), .feedbackRfInput(fbIn), .intValue(act.n),
      .fracValue(act.f), .stepDenominator(act.m), .refDivRatio(act.r),
      .doublerOn(act.d), .controlWord(act.c), .noiseWord(act.s),
      .compareTick(cTick), .feedbackTick(fTick), .lockDetect(lock));
   ssdc_props i_ssdc_props (.clk(clk), .rst(rst), .sclk(link.sclk),
      .sdata(link.sdata), .loadStrobe(link.loadStrobe),
      .observeOut(link.observeOut));
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic give_verdict();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp_snap(input ssdc_snap_t x, input ssdc_snap_t y);
      cmp_count++;
      if (x !== y) begin
         errors++;
         $display("wrong value latches exp %h got %h", x, y);
      end
   endtask
   task automatic cmp_num(input string nm, input int x, input int y);
      cmp_count++;
      if (x != y) begin
         errors++;
         $display("wrong value %s exp %0d got %0d", nm, x, y);
      end
   endtask
   task automatic cmp_bit(input logic x, input logic y);
      cmp_count++;
      if (x !== y) begin
         errors++;
         $display("wrong value observe exp %b got %b", x, y);
      end
   endtask
   task automatic send(input logic [23:0] w);
      int i;
      @(posedge clk);
      start <= 1'b1;
      word <= w;
      @(posedge clk);
      start <= 1'b0;
      case (w[1:0])
         ssdc_pkg::SEL_NDIV: begin
            e.n = w[22:14];
            e.f = w[13:2];
            e.m = pendMod;
         end
         ssdc_pkg::SEL_RDIV: begin
            e.r = w[17:14];
            pendMod = w[13:2];
         end
         ssdc_pkg::SEL_CTRL: begin
            e.c = w;
            e.d = w[11];
         end
         default: e.s = w;
      endcase
      q.push_back(e);
      i = 0;
      while (done !== 1'b1 && i < 400) begin
         @(posedge clk);
         #1;
         i++;
      end
   endtask
   // span in clk cycles from one tick to the n-th following tick
   task automatic span(input bit fb, input int n, output int g);
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while ((fb ? fTick : cTick) !== 1'b1 && i < 999);
      g = 0;
      repeat (n) begin
         do begin
            @(posedge clk);
            g++;
         end while ((fb ? fTick : cTick) !== 1'b1 && g < 999);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      reference_input <= ~reference_input;
      fbIn <= ~fbIn;
      dly <= obsSel == 1 ? lock : obsSel == 2 ? fTick :
         obsSel == 3 ? cTick : 1'b0;
   end
   initial begin
      forever begin
         @(posedge clk);
         if (done === 1'b1) begin
            if (q.size() == 0) begin
               errors++;
            end else begin
               cmp_snap(q.pop_front(), act);
            end
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end
   initial begin
      int g;
      logic [23:0] w;
      rst = 1'b1;
      start = 1'b0;
      word = 24'h000000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      e = '0;
      e.m = ssdc_pkg::MOD_RESET;
      pendMod = e.m;
      @(posedge clk);
      cmp_snap(e, act);
      send({4'h0, 2'h0, 4'h3, 12'h005, ssdc_pkg::SEL_RDIV});
      // numerator 1 stays below modulus 5, modulus within its range
      send({1'h0, 9'h01F, 12'h001, ssdc_pkg::SEL_NDIV});
      repeat (3) begin
         lfsr = nxt(lfsr);
         w = {lfsr[21:0], ssdc_pkg::SEL_CTRL};
         w[11] = 1'b0;
         send(w);
         send({lfsr[29:8], ssdc_pkg::SEL_NOISE});
      end
      span(1'b0, 1, g);
      cmp_num("compare gap", 6, g);
      span(1'b1, 5, g);
      cmp_num("feedback span", 312, g);
      for (int k = 0; k < 4; k++) begin
         // the device switches at the load, one cycle before done arrives
         obsSel = k;
         send({1'h0, k[2:0], 2'h0, 4'h3, 12'h005, ssdc_pkg::SEL_RDIV});
         repeat (80) begin
            @(posedge clk);
            cmp_bit(dly, link.observeOut);
         end
      end
      send({12'h000, 1'b1, 9'h000, ssdc_pkg::SEL_CTRL});
      span(1'b0, 1, g);
      cmp_num("doubled gap", 3, g);
      @(posedge clk);
      give_verdict();
   end
endmodule
`default_nettype wire
